// ---- inc/ldss_consts.vh ----
`ifndef LDSS_CONSTS_VH
`define LDSS_CONSTS_VH

// ************************************************************
// Register indexes (byte address is index times four)
// ************************************************************
`define LDSS_IDX_CTRL0      10'h080
`define LDSS_IDX_CTRL5      10'h085
`define LDSS_IDX_SAMPLE     10'h087
`define LDSS_IDX_STATUS     10'h08f
`define LDSS_NUM_CTRL       3'h6

// ************************************************************
// Memory addresses
// ************************************************************
`define LDSS_NV_CTRL_BASE   9'h080
`define LDSS_TABLE_ONE_BASE 9'h090
`define LDSS_TABLE_TWO_BASE 9'h0d0

// ************************************************************
// Field positions
// ************************************************************
`define LDSS_C0_DIR_ONE     0
`define LDSS_C0_DIR_TWO     1
`define LDSS_C0_FILT_DIS    2
`define LDSS_C5_FS_ONE_LO   0
`define LDSS_C5_FS_TWO_LO   2
`define LDSS_C5_TBL_ONE_DIR 4
`define LDSS_C5_CONV_ONE_DIR 5
`define LDSS_C5_TBL_TWO_DIR 6
`define LDSS_C5_CONV_TWO_DIR 7
`define LDSS_ROW_MASK       8'h3f
`define LDSS_CTRL_RESET     8'h00

// ************************************************************
// Filter
// ************************************************************
`define LDSS_FILTER_COUNT   3'h4

`endif

// ---- hw/ldss_top.v ----
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`include "ldss_consts.vh"

module ldss_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        por_ok,
    input  wire        sampler_ready,
    input  wire        conv_done,
    input  wire [7:0]  conv_result,
    output reg         nv_rd_en,
    output reg  [8:0]  nv_rd_addr,
    input  wire [7:0]  nv_rd_data,
    output reg         analog_enable,
    output reg         sampler_enable,
    output reg  [7:0]  conv_one_byte,
    output reg  [7:0]  conv_two_byte,
    output wire        output_one_direction,
    output wire        output_two_direction,
    output wire [1:0]  output_one_full_scale,
    output wire [1:0]  output_two_full_scale
);

    // ************************************************************
    // Sequencer states
    // ************************************************************
    localparam [4:0] ST_OFF    = 5'h01;
    localparam [4:0] ST_RECALL = 5'h02;
    localparam [4:0] ST_WAIT   = 5'h04;
    localparam [4:0] ST_FILTER = 5'h08;
    localparam [4:0] ST_RUN    = 5'h10;

    reg  [4:0]  state_ff;
    reg  [4:0]  nxt_state;
    reg  [7:0]  ctrl_ff [0:5];
    reg  [2:0]  rc_cnt_ff;
    reg         rc_pend_ff;
    reg  [2:0]  rc_idx_ff;
    reg  [7:0]  sampled_ff;
    reg  [7:0]  last_conv_ff;
    reg  [2:0]  match_cnt_ff;
    reg         sample_valid_ff;
    reg         fetch_ch_ff;
    reg         fetch_pend_ff;
    reg         pend_ch_ff;
    reg  [7:0]  table_one_byte_ff;
    reg  [7:0]  table_two_byte_ff;
    reg  [1:0]  fetched_ff;
    reg         live_ff;
    reg         wr_pend_ff;
    reg  [9:0]  wr_idx_ff;
    reg  [7:0]  nxt_conv_one;
    reg  [7:0]  nxt_conv_two;
    reg  [31:0] nxt_rdata;
    wire [9:0]  a_idx;
    wire        a_take;
    wire        filt_dis;
    wire [5:0]  row_one;
    wire [5:0]  row_two;
    wire [2:0]  nxt_match;
    wire        same_val;
    wire        w_ctrl;
    wire [2:0]  w_ctrl_idx;
    integer     i;

    assign hreadyout = clk_en;
    assign hresp     = 1'b0;
    assign a_idx     = haddr[11:2];
    assign a_take    = hsel & hready & htrans[1];
    assign filt_dis  = ctrl_ff[0][`LDSS_C0_FILT_DIS];

    // ************************************************************
    // Settings seen by the analog side
    // ************************************************************
    assign output_one_direction  = ctrl_ff[0][`LDSS_C0_DIR_ONE];
    assign output_two_direction  = ctrl_ff[0][`LDSS_C0_DIR_TWO];
    assign output_one_full_scale = ctrl_ff[5][`LDSS_C5_FS_ONE_LO +: 2];
    assign output_two_full_scale = ctrl_ff[5][`LDSS_C5_FS_TWO_LO +: 2];

    // ************************************************************
    // Row selection
    // ************************************************************
    assign row_one = ctrl_ff[5][`LDSS_C5_TBL_ONE_DIR] ? ctrl_ff[1][5:0]
                                                       : sampled_ff[7:2];
    assign row_two = ctrl_ff[5][`LDSS_C5_TBL_TWO_DIR] ? ctrl_ff[2][5:0]
                                                       : sampled_ff[7:2];

    // ************************************************************
    // Power-up sequencer
    // ************************************************************
    always @* begin
        case (state_ff)
            ST_OFF:    nxt_state = ST_RECALL;
            ST_RECALL: nxt_state = (rc_pend_ff && rc_idx_ff == `LDSS_NUM_CTRL - 3'h1)
                                   ? ST_WAIT : ST_RECALL;
            ST_WAIT:   nxt_state = sampler_ready ? ST_FILTER : ST_WAIT;
            ST_FILTER: nxt_state = sample_valid_ff ? ST_RUN : ST_FILTER;
            ST_RUN:    nxt_state = ST_RUN;
            default:   nxt_state = ST_OFF;
        endcase
        if (!por_ok) begin
            nxt_state = ST_OFF;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff       <= ST_OFF;
            rc_cnt_ff      <= 3'h0;
            rc_pend_ff     <= 1'b0;
            rc_idx_ff      <= 3'h0;
            analog_enable  <= 1'b0;
            sampler_enable <= 1'b0;
        end else if (clk_en) begin
            state_ff       <= nxt_state;
            analog_enable  <= (nxt_state & (ST_WAIT | ST_FILTER | ST_RUN)) != 5'h00;
            sampler_enable <= (nxt_state & (ST_FILTER | ST_RUN)) != 5'h00;
            rc_pend_ff     <= (state_ff == ST_RECALL) && (rc_cnt_ff < `LDSS_NUM_CTRL);
            rc_idx_ff      <= rc_cnt_ff;
            if (state_ff == ST_RECALL && rc_cnt_ff < `LDSS_NUM_CTRL) begin
                rc_cnt_ff <= rc_cnt_ff + 3'h1;
            end else if (state_ff != ST_RECALL) begin
                rc_cnt_ff <= 3'h0;
            end
        end
    end

    // ************************************************************
    // Sample filter
    // ************************************************************
    assign same_val  = sample_valid_ff ? (conv_result[7:2] == last_conv_ff[7:2])
                                       : (conv_result == last_conv_ff);
    assign nxt_match = (same_val && match_cnt_ff != 3'h0)
                       ? ((match_cnt_ff == `LDSS_FILTER_COUNT) ? match_cnt_ff
                                                              : match_cnt_ff + 3'h1)
                       : 3'h1;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sampled_ff      <= 8'h00;
            last_conv_ff    <= 8'h00;
            match_cnt_ff    <= 3'h0;
            sample_valid_ff <= 1'b0;
        end else if (clk_en) begin
            if (!sampler_enable) begin
                match_cnt_ff    <= 3'h0;
                sample_valid_ff <= 1'b0;
            end else if (conv_done) begin
                last_conv_ff <= conv_result;
                match_cnt_ff <= nxt_match;
                if (filt_dis || nxt_match == `LDSS_FILTER_COUNT) begin
                    sampled_ff      <= conv_result;
                    sample_valid_ff <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Memory port: recall then alternating table fetches
    // ************************************************************
    always @* begin
        nv_rd_en   = 1'b0;
        nv_rd_addr = 9'h000;
        if (state_ff == ST_RECALL && rc_cnt_ff < `LDSS_NUM_CTRL) begin
            nv_rd_en   = 1'b1;
            nv_rd_addr = `LDSS_NV_CTRL_BASE + {6'h00, rc_cnt_ff};
        end else if (state_ff == ST_RUN) begin
            nv_rd_en   = 1'b1;
            nv_rd_addr = fetch_ch_ff ? `LDSS_TABLE_TWO_BASE + {3'h0, row_two}
                                     : `LDSS_TABLE_ONE_BASE + {3'h0, row_one};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_ch_ff       <= 1'b0;
            fetch_pend_ff     <= 1'b0;
            pend_ch_ff        <= 1'b0;
            table_one_byte_ff <= 8'h00;
            table_two_byte_ff <= 8'h00;
            fetched_ff        <= 2'h0;
            live_ff           <= 1'b0;
        end else if (clk_en) begin
            fetch_pend_ff <= (state_ff == ST_RUN);
            pend_ch_ff    <= fetch_ch_ff;
            fetch_ch_ff   <= (state_ff == ST_RUN) ? ~fetch_ch_ff : 1'b0;
            if (state_ff != ST_RUN) begin
                fetched_ff <= 2'h0;
                live_ff    <= 1'b0;
            end else begin
                if (fetch_pend_ff) begin
                    if (pend_ch_ff) begin
                        table_two_byte_ff <= nv_rd_data;
                        fetched_ff[1]     <= 1'b1;
                    end else begin
                        table_one_byte_ff <= nv_rd_data;
                        fetched_ff[0]     <= 1'b1;
                    end
                end
                if (fetched_ff == 2'h3) begin
                    live_ff <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Converter input bytes
    // ************************************************************
    always @* begin
        nxt_conv_one = ctrl_ff[5][`LDSS_C5_CONV_ONE_DIR] ? ctrl_ff[3]
                                                          : table_one_byte_ff;
        nxt_conv_two = ctrl_ff[5][`LDSS_C5_CONV_TWO_DIR] ? ctrl_ff[4]
                                                          : table_two_byte_ff;
        // Zero in step with analog_enable when the supply fails
        if (!live_ff || nxt_state != ST_RUN) begin
            nxt_conv_one = 8'h00;
            nxt_conv_two = 8'h00;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_one_byte <= 8'h00;
            conv_two_byte <= 8'h00;
        end else if (clk_en) begin
            conv_one_byte <= nxt_conv_one;
            conv_two_byte <= nxt_conv_two;
        end
    end

    // ************************************************************
    // AHB-Lite register slave
    // ************************************************************
    assign w_ctrl     = wr_pend_ff && wr_idx_ff >= `LDSS_IDX_CTRL0
                        && wr_idx_ff <= `LDSS_IDX_CTRL5;
    assign w_ctrl_idx = wr_idx_ff[2:0];

    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (a_idx >= `LDSS_IDX_CTRL0 && a_idx <= `LDSS_IDX_CTRL5) begin
            nxt_rdata = {24'h000000, ctrl_ff[a_idx[2:0]]};
        end else if (a_idx == `LDSS_IDX_SAMPLE) begin
            nxt_rdata = {24'h000000, sampled_ff};
        end else if (a_idx == `LDSS_IDX_STATUS) begin
            nxt_rdata = {conv_two_byte, conv_one_byte, 3'h0, state_ff, 7'h00, live_ff};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata     <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 10'h000;
            for (i = 0; i < 6; i = i + 1) begin
                ctrl_ff[i] <= `LDSS_CTRL_RESET;
            end
        end else if (clk_en) begin
            wr_pend_ff <= a_take & hwrite;
            wr_idx_ff  <= a_idx;
            if (a_take && !hwrite) begin
                hrdata <= nxt_rdata;
            end
            if (rc_pend_ff && state_ff == ST_RECALL) begin
                ctrl_ff[rc_idx_ff] <= nv_rd_data;
            end else if (w_ctrl) begin
                if (w_ctrl_idx == 3'h1 || w_ctrl_idx == 3'h2) begin
                    ctrl_ff[w_ctrl_idx] <= hwdata[7:0] & `LDSS_ROW_MASK;
                end else begin
                    ctrl_ff[w_ctrl_idx] <= hwdata[7:0];
                end
            end
        end
    end

endmodule // ldss_top

// ---- verification/ldss_top_checker.sv ----
`include "ldss_consts.vh"

module ldss_top_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        clk_en,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        sampler_ready,
    input wire        nv_rd_en,
    input wire [8:0]  nv_rd_addr,
    input wire        analog_enable,
    input wire        sampler_enable,
    input wire [7:0]  conv_one_byte,
    input wire [7:0]  conv_two_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Six control words fetched on back-to-back cycles
    sequence recall_words;
        nv_rd_addr == 9'h080 ##1 nv_rd_en && nv_rd_addr == 9'h081
        ##1 nv_rd_en && nv_rd_addr == 9'h082 ##1 nv_rd_en && nv_rd_addr == 9'h083
        ##1 nv_rd_en && nv_rd_addr == 9'h084 ##1 nv_rd_en && nv_rd_addr == 9'h085;
    endsequence

    recall_order_a: assert property (nv_rd_en && nv_rd_addr == 9'h080 |-> recall_words ##[1:3] analog_enable)
        else $error("recall order or analog enable wrong");
    conv_zero_a: assert property (!analog_enable |-> conv_one_byte == 8'h00 && conv_two_byte == 8'h00)
        else $error("converter byte not zero before start");
    sampler_gate_a: assert property ($rose(sampler_enable) |-> $past(sampler_ready))
        else $error("sampler enabled without ready");
    table_range_a: assert property (nv_rd_en && analog_enable |-> nv_rd_addr >= `LDSS_TABLE_ONE_BASE
        && nv_rd_addr <= `LDSS_TABLE_TWO_BASE + 9'h03f)
        else $error("table read outside tables");
    table_alternate_a: assert property (clk_en && nv_rd_en && analog_enable
        && nv_rd_addr < `LDSS_TABLE_TWO_BASE
        |=> nv_rd_en && nv_rd_addr >= `LDSS_TABLE_TWO_BASE)
        else $error("table two not read after table one");
    unmapped_zero_a: assert property (hsel && htrans[1] && hready && clk_en && !hwrite
        && haddr[11:2] < 10'h080 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    ready_follow_a: assert property (hreadyout == clk_en)
        else $error("ready does not follow clock enable");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule // ldss_top_checker

// ---- verification/ldss_nv_model.sv ----
module ldss_nv_model (
    input  wire        hclk,
    input  wire        nv_rd_en,
    input  wire [8:0]  nv_rd_addr,
    output logic [7:0] nv_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Control words read as zero, table bytes follow the address
    always @(posedge hclk) begin
        if (nv_rd_en && nv_rd_addr >= 9'h090) begin
            nv_rd_data <= nv_rd_addr[7:0] ^ 8'h3c;
        end else if (nv_rd_en) begin
            nv_rd_data <= 8'h00;
        end else begin
            nv_rd_data <= ~nv_rd_data;
        end
    end
    initial nv_rd_data = 8'h00;
endmodule // ldss_nv_model

// ---- verification/test_lut_dac_source_select.sv ----
`include "ldss_consts.vh"

module test_lut_dac_source_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, conv_done = 1'b0;
    logic        por_ok = 1'b1, sampler_ready = 1'b1, clk_en = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [7:0]  conv_result = 8'h00, conv_one_byte, conv_two_byte, nv_rd_data;
    logic [8:0]  nv_rd_addr;
    logic [1:0]  fs1, fs2;
    wire         hready, hreadyout;
    logic        hresp, nv_rd_en, analog_enable, sampler_enable, dir1, dir2;
    int          miscompares = 0, num_checks = 0;
    logic [7:0]  sel [5] = '{8'h10, 8'h50, 8'hf0, 8'ha0, 8'h00};
    logic [7:0]  e1 [5] = '{8'ha9, 8'ha9, 8'ha7, 8'ha7, 8'h8d};
    logic [7:0]  e2 [5] = '{8'hcd, 8'h33, 8'h5e, 8'h5e, 8'hcd};
    assign hready = hreadyout;

    ldss_top ldss_top_inst (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .por_ok, .sampler_ready,
        .conv_done, .conv_result, .nv_rd_en, .nv_rd_addr, .nv_rd_data, .analog_enable,
        .sampler_enable, .conv_one_byte, .conv_two_byte, .output_one_direction(dir1),
        .output_two_direction(dir2), .output_one_full_scale(fs1), .output_two_full_scale(fs2));
    ldss_nv_model ldss_nv_model_inst (.hclk, .nv_rd_en, .nv_rd_addr, .nv_rd_data);

    // ************************************************************
    // Bus cycles and comparisons
    // ************************************************************
    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        num_checks++;
        if (act !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic pulse(input logic [7:0] v);
        conv_done <= 1'b1;
        conv_result <= v;
        @(posedge hclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    task automatic expect_bytes(input logic [7:0] x1, input logic [7:0] x2);
        int n = 0;
        while (n < 40 && !(conv_one_byte === x1 && conv_two_byte === x2)) begin
            @(posedge hclk);
            n++;
        end
        check({conv_two_byte, conv_one_byte}, {x2, x1});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (30) @(posedge hclk);
        check({analog_enable, sampler_enable}, 2'h3);
        repeat (3) pulse(8'h84);
        repeat (10) @(posedge hclk);
        check({conv_two_byte, conv_one_byte}, 16'h0);
        pulse(8'h84);
        expect_bytes(8'h8d, 8'hcd);
        bus(1'b1, `LDSS_IDX_CTRL0 + 10'h1, 32'h05);
        bus(1'b1, `LDSS_IDX_CTRL0 + 10'h2, 32'h3f);
        bus(1'b1, `LDSS_IDX_CTRL0 + 10'h3, 32'ha7);
        bus(1'b1, `LDSS_IDX_CTRL0 + 10'h4, 32'h5e);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `LDSS_IDX_CTRL5, {24'h0, sel[i]});
            expect_bytes(e1[i], e2[i]);
        end
        bus(1'b1, `LDSS_IDX_CTRL0, 32'h07);
        bus(1'b1, `LDSS_IDX_CTRL5, 32'h0d);
        @(posedge hclk);
        check({dir2, dir1, fs2, fs1}, 6'h3d);
        bus(1'b0, `LDSS_IDX_CTRL5, 32'h0);
        check(rdv, 32'h0d);
        pulse(8'hf3);
        expect_bytes(8'hf0, 8'h30);
        clk_en <= 1'b0;
        pulse(8'h84);
        check({hreadyout, conv_two_byte, conv_one_byte}, {1'b0, 16'h30f0});
        clk_en <= 1'b1;
        bus(1'b0, `LDSS_IDX_SAMPLE, 32'h0);
        check(rdv, 32'hf3);
        bus(1'b0, 10'h000, 32'h0);
        check(rdv, 32'h0);
        hresetn <= 1'b0;
        por_ok <= 1'b0;
        sampler_ready <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        check({analog_enable, nv_rd_en, conv_two_byte, conv_one_byte}, 18'h0);
        por_ok <= 1'b1;
        repeat (20) @(posedge hclk);
        check({analog_enable, sampler_enable}, 2'h2);
        sampler_ready <= 1'b1;
        repeat (3) @(posedge hclk);
        check(sampler_enable, 1'b1);
        repeat (2) pulse(8'h84);
        repeat (3) pulse(8'h85);
        repeat (10) @(posedge hclk);
        check({conv_two_byte, conv_one_byte}, 16'h0);
        pulse(8'h85);
        expect_bytes(8'h8d, 8'hcd);
        bus(1'b0, `LDSS_IDX_SAMPLE, 32'h0);
        check(rdv, 32'h85);
        repeat (3) pulse(8'h88);
        check({conv_two_byte, conv_one_byte}, 16'hcd8d);
        pulse(8'h8b);
        expect_bytes(8'h8e, 8'hce);
        bus(1'b0, `LDSS_IDX_STATUS, 32'h0);
        check(rdv, 32'hce8e_1001);
        tally_and_finish;
    end
endmodule // test_lut_dac_source_select

bind ldss_top ldss_top_checker ldss_top_checker_inst (.hclk, .hresetn, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .sampler_ready, .nv_rd_en,
    .nv_rd_addr, .analog_enable, .sampler_enable, .conv_one_byte, .conv_two_byte);
